//--- hcx_top.sv
// Host control upper half and PCI address extension registers
`timescale 1ns/1ps
module hcx_top
  import hcx_pkg::*;
(
  input  logic              clock,          // Fast clock
  input  logic              rst_n,          // Sync reset, active low
  input  logic [ADDR_W-1:0] addr,           // Register byte address
  input  logic              wr,             // Write strobe
  input  logic              rd,             // Read strobe
  input  logic [31:0]       wdata,          // Write data
  output logic [31:0]       rdata,          // Read data, registered
  input  logic              discard_event,  // Timer zero with data dropped
  input  logic              irq_enable,     // Normal interrupt enable
  input  logic              fiq_enable,     // Fast interrupt enable
  output logic              irq,            // Normal interrupt request
  output logic              fiq,            // Fast interrupt request
  input  logic              central_strap,  // Central function strap
  output logic              pci_rst_n,      // PCI bus reset, active low
  output logic              fifo_flush,     // FIFO reset while software PCI reset bit clear, with or without central strap
  input  logic              enq_req,        // Processor to PCI enqueue request
  output logic              enq_ok,         // Enqueue allowed
  output logic [16:0]       list_mask,      // Counting pointer bits mask
  output logic [2:0]        list_size,      // List size code
  input  logic              timer4_zero,    // Timer 4 reached zero
  output logic              wdog_reset,     // Processor reset from watchdog
  input  logic [1:0]        rom_width_strap_pins, // ROM width strap
  output logic [1:0]        rom_width,      // Captured ROM width
  output logic [4:0]        rom_access,     // First access cycles
  output logic [4:0]        rom_burst,      // Burst access cycles
  output logic [3:0]        rom_tristate,   // Tristate cycles
  output logic              rom_time_bad,   // Illegal timing value set
  output logic [2:0]        xcs_dir,        // Chip-select directions
  output logic              pci_a31,        // PCI address bit 31
  output logic [15:0]       pci_io_hi,      // PCI I/O address 31:16
  input  logic              serr_enable,    // Command register error enable
  output logic              serr_n          // System error pulse, active low
);
  import hcx_pkg::*;

  hcx_bus_if bus ();

  hcx_decode u_dec (
    .addr (addr),
    .wr   (wr),
    .rd   (rd),
    .bus  (bus)
  );

  // ****************************************
  // Register state
  // ****************************************
  logic        discard_r, discard_nxt;
  logic        norst_r, norst_nxt;
  logic [2:0]  lsz_r, lsz_nxt;
  logic        wdog_r, wdog_nxt;
  logic [1:0]  rw_r, rw_nxt;
  logic [3:0]  acc_r, acc_nxt;
  logic [3:0]  bst_r, bst_nxt;
  logic [3:0]  tri_r, tri_nxt;
  logic [2:0]  xcs_r, xcs_nxt;
  logic        serr_req_r, serr_req_nxt;
  logic        a31_r, a31_nxt;
  logic [15:0] ioa_r, ioa_nxt;
  logic [31:0] ctrl_view;
  logic [31:0] ext_view;

  function automatic logic [4:0] cyc(input logic [3:0] v);
    cyc = (v == TIME_ZERO) ? TIME_ZERO_VAL : {1'b0, v};
  endfunction

  always_comb begin
    discard_nxt = discard_r;
    if (bus.wr_ctrl && !wdata[BIT_DISCARD]) begin
      discard_nxt = 1'b0;
    end
    if (discard_event) begin
      discard_nxt = 1'b1;
    end
    norst_nxt    = norst_r;
    lsz_nxt      = lsz_r;
    acc_nxt      = acc_r;
    bst_nxt      = bst_r;
    tri_nxt      = tri_r;
    xcs_nxt      = xcs_r;
    serr_req_nxt = 1'b0;
    wdog_nxt     = wdog_r;
    if (bus.wr_ctrl) begin
      norst_nxt    = wdata[BIT_PCI_NORST];
      lsz_nxt      = wdata[LSZ_HI:LSZ_LO];
      acc_nxt      = wdata[ACC_HI:ACC_LO];
      bst_nxt      = wdata[BST_HI:BST_LO];
      tri_nxt      = wdata[TRI_HI:TRI_LO];
      xcs_nxt      = wdata[XCS_HI:XCS_LO];
      serr_req_nxt = wdata[BIT_SERR_REQ];
      if (wdata[BIT_WDOG]) begin
        wdog_nxt = 1'b1;
      end
    end
    rw_nxt  = rw_r;
    a31_nxt = a31_r;
    ioa_nxt = ioa_r;
    if (bus.wr_ext) begin
      a31_nxt = wdata[BIT_MEM_A31];
      ioa_nxt = wdata[IOA_HI:IOA_LO];
    end
    if (bus.wr_dac_lo) begin
      a31_nxt = 1'b0;
    end
    if (bus.wr_dac_hi) begin
      a31_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      discard_r  <= 1'b0;
      norst_r    <= 1'b0;
      lsz_r      <= 3'h0;
      wdog_r     <= 1'b0;
      rw_r       <= rom_width_strap_pins;
      acc_r      <= 4'h0;
      bst_r      <= 4'h0;
      tri_r      <= 4'h0;
      xcs_r      <= 3'h0;
      serr_req_r <= 1'b0;
      a31_r      <= 1'b0;
      ioa_r      <= 16'h0000;
    end else begin
      discard_r  <= discard_nxt;
      norst_r    <= norst_nxt;
      lsz_r      <= lsz_nxt;
      wdog_r     <= wdog_nxt;
      rw_r       <= rw_nxt;
      acc_r      <= acc_nxt;
      bst_r      <= bst_nxt;
      tri_r      <= tri_nxt;
      xcs_r      <= xcs_nxt;
      serr_req_r <= serr_req_nxt;
      a31_r      <= a31_nxt;
      ioa_r      <= ioa_nxt;
    end
  end

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (LSZ_HI - LSZ_LO + 1 != $bits(lsz_r)) begin : g_lsz_chk
    $error("List size field width mismatch");
  end
  if (LIST_BASE_BIT + (1 << $bits(lsz_r)) - 1 >= $bits(list_mask)) begin : g_mask_chk
    $error("List mask too narrow for largest size code");
  end
  if (ACC_HI - ACC_LO + 1 != $bits(acc_r)) begin : g_acc_chk
    $error("Access time field width mismatch");
  end
  if (BST_HI - BST_LO + 1 != $bits(bst_r)) begin : g_bst_chk
    $error("Burst time field width mismatch");
  end
  if (TRI_HI - TRI_LO + 1 != $bits(tri_r)) begin : g_tri_chk
    $error("Tristate time field width mismatch");
  end
  if (XCS_HI - XCS_LO + 1 != $bits(xcs_r)) begin : g_xcs_chk
    $error("Chip-select direction field width mismatch");
  end
  if (IOA_HI - IOA_LO + 1 != $bits(ioa_r)) begin : g_ioa_chk
    $error("I/O address field width mismatch");
  end

  // ****************************************
  // Read views
  // ****************************************
  always_comb begin
    ctrl_view = ZERO32;
    ctrl_view[BIT_DISCARD]   = discard_r;
    ctrl_view[BIT_PCI_NORST] = norst_r;
    ctrl_view[LSZ_HI:LSZ_LO] = lsz_r;
    ctrl_view[BIT_WDOG]      = wdog_r;
    ctrl_view[RW_HI:RW_LO]   = rw_r;
    ctrl_view[ACC_HI:ACC_LO] = acc_r;
    ctrl_view[BST_HI:BST_LO] = bst_r;
    ctrl_view[TRI_HI:TRI_LO] = tri_r;
    ctrl_view[XCS_HI:XCS_LO] = xcs_r;
    ext_view = ZERO32;
    ext_view[BIT_MEM_A31]   = a31_r;
    ext_view[IOA_HI:IOA_LO] = ioa_r;
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic [31:0] rdata_nxt;
  logic [16:0] mask_nxt;
  logic        bad_nxt;

  always_comb begin
    rdata_nxt = ZERO32;
    if (bus.rd_hit) begin
      if (addr == OFS_HOST_CTRL) begin
        rdata_nxt = ctrl_view;
      end else if (addr == OFS_ADDR_EXT) begin
        rdata_nxt = ext_view;
      end else begin
        rdata_nxt[0] = a31_r;
      end
    end
    mask_nxt = 17'h0;
    for (int i = 2; i <= 16; i++) begin
      if (i <= LIST_BASE_BIT + int'(lsz_nxt)) begin
        mask_nxt[i] = 1'b1;
      end
    end
    bad_nxt = (acc_nxt == TIME_BAD_ONE) || (acc_nxt == TIME_BAD_TWO)
              || (bst_nxt == TIME_BAD_ONE) || (bst_nxt == TIME_BAD_TWO)
              || (tri_nxt == TIME_BAD_ONE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata        <= ZERO32;
      irq          <= 1'b0;
      fiq          <= 1'b0;
      pci_rst_n    <= 1'b1;
      fifo_flush   <= 1'b0;
      enq_ok       <= 1'b0;
      list_mask    <= LIST_MASK_RST;
      list_size    <= 3'h0;
      wdog_reset   <= 1'b0;
      // Strap shown from reset on, no step at release
      rom_width    <= rom_width_strap_pins;
      rom_access   <= TIME_ZERO_VAL;
      rom_burst    <= TIME_ZERO_VAL;
      rom_tristate <= 4'h0;
      rom_time_bad <= 1'b0;
      xcs_dir      <= 3'h0;
      pci_a31      <= 1'b0;
      pci_io_hi    <= 16'h0000;
      serr_n       <= 1'b1;
    end else begin
      rdata        <= rdata_nxt;
      irq          <= discard_nxt && irq_enable;
      fiq          <= discard_nxt && fiq_enable;
      pci_rst_n    <= !(!norst_nxt && central_strap);
      fifo_flush   <= !norst_nxt;
      enq_ok       <= enq_req && norst_nxt;
      list_mask    <= mask_nxt;
      list_size    <= lsz_nxt;
      wdog_reset   <= wdog_r && timer4_zero;
      rom_width    <= rw_r;
      rom_access   <= cyc(acc_nxt);
      rom_burst    <= cyc(bst_nxt);
      rom_tristate <= tri_nxt;
      rom_time_bad <= bad_nxt;
      xcs_dir      <= xcs_nxt;
      pci_a31      <= a31_nxt;
      pci_io_hi    <= ioa_nxt;
      serr_n       <= !(serr_req_r && !central_strap && serr_enable);
    end
  end
endmodule

//--- hcx_pkg.sv
// Package with register offsets, field positions and reset values
package hcx_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_ADDR_EXT  = 12'h140;
  localparam logic [ADDR_W-1:0] OFS_HOST_CTRL = 12'h13C;
  localparam logic [ADDR_W-1:0] OFS_DAC_LO    = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_DAC_HI    = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_A31_ALIAS = 12'h20C;

  localparam int BIT_DISCARD   = 8;
  localparam int BIT_PCI_NORST = 9;
  localparam int LSZ_LO        = 10;
  localparam int LSZ_HI        = 12;
  localparam int BIT_WDOG      = 13;
  localparam int RW_LO         = 14;
  localparam int RW_HI         = 15;
  localparam int ACC_LO        = 16;
  localparam int ACC_HI        = 19;
  localparam int BST_LO        = 20;
  localparam int BST_HI        = 23;
  localparam int TRI_LO        = 24;
  localparam int TRI_HI        = 27;
  localparam int XCS_LO        = 28;
  localparam int XCS_HI        = 30;
  localparam int BIT_SERR_REQ  = 1;
  localparam int BIT_MEM_A31   = 15;
  localparam int IOA_LO        = 16;
  localparam int IOA_HI        = 31;

  localparam int LIST_BASE_BIT = 9;
  localparam logic [3:0] TIME_ZERO     = 4'h0;
  localparam logic [4:0] TIME_ZERO_VAL = 5'h10;
  localparam logic [1:0] RW_BYTE  = 2'h3;
  localparam logic [1:0] RW_WORD  = 2'h1;
  localparam logic [1:0] RW_DWORD = 2'h2;
  localparam logic [31:0] ZERO32  = 32'h0000_0000;
  localparam logic [3:0] TIME_BAD_ONE  = 4'h1;
  localparam logic [3:0] TIME_BAD_TWO  = 4'h2;
  localparam logic [16:0] LIST_MASK_RST = 17'h003FC;
endpackage

//--- hcx_bus_if.sv
// Interface carrying decoded write strobes between top and decoder
`timescale 1ns/1ps
interface hcx_bus_if;
  logic wr_ctrl;
  logic wr_ext;
  logic wr_dac_lo;
  logic wr_dac_hi;
  logic rd_hit;
  modport dec (output wr_ctrl, wr_ext, wr_dac_lo, wr_dac_hi, rd_hit);
  modport core (input wr_ctrl, wr_ext, wr_dac_lo, wr_dac_hi, rd_hit);
endinterface

//--- hcx_decode.sv
// Address decoder producing write strobes and read hit
`timescale 1ns/1ps
module hcx_decode
  import hcx_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,  // Byte address
  input  wire logic              wr,    // Write strobe
  input  wire logic              rd,    // Read strobe
  hcx_bus_if.dec                 bus    // Decoded strobes
);
  always_comb begin
    bus.wr_ctrl   = wr && (addr == OFS_HOST_CTRL);
    bus.wr_ext    = wr && (addr == OFS_ADDR_EXT);
    bus.wr_dac_lo = wr && (addr == OFS_DAC_LO);
    bus.wr_dac_hi = wr && (addr == OFS_DAC_HI);
    bus.rd_hit    = rd && ((addr == OFS_HOST_CTRL) || (addr == OFS_ADDR_EXT)
                    || (addr == OFS_A31_ALIAS));
  end
endmodule

//--- hcx_top_sva.sv
// Concurrent checks on the ports of the host control block
`timescale 1ns/1ps
module hcx_top_sva (
  input logic        clock,         // Fast clock
  input logic        rst_n,         // Sync reset
  input logic        enq_req,       // Enqueue request
  input logic        enq_ok,        // Enqueue allowed
  input logic        fifo_flush,    // FIFO flush
  input logic        pci_rst_n,     // PCI reset
  input logic        central_strap, // Central strap
  input logic        irq,           // Normal request
  input logic        fiq,           // Fast request
  input logic        irq_enable,    // Normal enable
  input logic        fiq_enable,    // Fast enable
  input logic        wdog_reset,    // Watchdog reset
  input logic        timer4_zero,   // Timer at zero
  input logic        serr_n,        // Error pulse
  input logic [1:0]  rom_width,     // Captured width
  input logic [16:0] list_mask,     // Pointer mask
  input logic [4:0]  rom_access,    // First access time
  input logic [4:0]  rom_burst      // Burst time
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_enq_needs_req: assert property (enq_ok |-> $past(enq_req))
    else $error("enqueue allowed without request");
  a_enq_blocked: assert property (fifo_flush && $past(fifo_flush) |-> !enq_ok)
    else $error("enqueue allowed during software reset");
  a_rst_with_flush: assert property (!pci_rst_n |-> fifo_flush)
    else $error("PCI reset without FIFO flush");
  a_rst_needs_cfn: assert property (!pci_rst_n |-> $past(central_strap))
    else $error("PCI reset without central strap");
  a_irq_gated: assert property (irq |-> $past(irq_enable))
    else $error("normal request while disabled");
  a_fiq_gated: assert property (fiq |-> $past(fiq_enable))
    else $error("fast request while disabled");
  a_wdog_gated: assert property (wdog_reset |-> $past(timer4_zero))
    else $error("watchdog reset without timer zero");
  a_serr_one_cycle: assert property ($fell(serr_n) |=> serr_n)
    else $error("error pulse longer than one cycle");
  a_width_held: assert property (rst_n && $past(rst_n) |-> $stable(rom_width))
    else $error("ROM width changed outside reset");
  a_mask_base: assert property (list_mask[9:0] == 10'h3FC)
    else $error("base pointer bits wrong");
  a_access_range: assert property (rom_access inside {[5'h01:5'h10]})
    else $error("access time out of range");
  a_burst_range: assert property (rom_burst inside {[5'h01:5'h10]})
    else $error("burst time out of range");
endmodule
bind hcx_top hcx_top_sva chk (.clock, .rst_n, .enq_req, .enq_ok, .fifo_flush, .pci_rst_n,
  .central_strap, .irq, .fiq, .irq_enable, .fiq_enable, .wdog_reset, .timer4_zero,
  .serr_n, .rom_width, .list_mask, .rom_access, .rom_burst);

//--- hcx_cpu_model.sv
// Processor core model issuing one-cycle register strobes
`timescale 1ns/1ps
module cpu_model (
  input  logic                         clock, // Fast clock
  output logic [hcx_pkg::ADDR_W-1:0]   addr,  // Byte address
  output logic                         wr,    // Write strobe
  output logic                         rd,    // Read strobe
  output logic [31:0]                  wdata  // Write data
);
  import hcx_pkg::*;
  initial begin
    addr = '0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = '0;
  end
  // Released address and data lines show the inverse of the last value, strobes drop low
  task automatic access(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic w);
    @(posedge clock);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clock);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule

//--- tb_hcx_top.sv
// Self-checking bench for the host control block
`timescale 1ns/1ps
module tb_hcx_top;
  import hcx_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  logic clock, rst_n, wr, rd, discard_event, irq_enable, fiq_enable, irq, fiq;
  logic central_strap, pci_rst_n, fifo_flush, enq_req, enq_ok, timer4_zero;
  logic wdog_reset, rom_time_bad, pci_a31, serr_enable, serr_n, rd_q;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata, w, seed;
  logic [16:0]       list_mask;
  logic [2:0]        list_size, xcs_dir;
  logic [1:0]        rom_width_strap_pins, rom_width;
  logic [4:0]        rom_access, rom_burst;
  logic [3:0]        rom_tristate;
  logic [15:0]       pci_io_hi;
  int                bad_count, comparisons, cnt;
  note_t             q[$], n;
  hcx_top dut (.clock, .rst_n, .addr, .wr, .rd, .wdata, .rdata, .discard_event, .irq_enable,
    .fiq_enable, .irq, .fiq, .central_strap, .pci_rst_n, .fifo_flush, .enq_req, .enq_ok,
    .list_mask, .list_size, .timer4_zero, .wdog_reset, .rom_width_strap_pins, .rom_width,
    .rom_access, .rom_burst, .rom_tristate, .rom_time_bad, .xcs_dir, .pci_a31, .pci_io_hi,
    .serr_enable, .serr_n);
  cpu_model cpu (.clock, .addr, .wr, .rd, .wdata);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task wreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    cpu.access(a, d, 1'b1);
    step(3);
  endtask
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    cpu.access(a, 32'h0000_0000, 1'b0);
  endtask
  task do_reset(input logic [1:0] s);
    rst_n = 1'b0;
    rom_width_strap_pins = s;
    step(10);
    rst_n = 1'b1;
    rom_width_strap_pins = ~s;
    step(2);
  endtask
  task final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) rd_q <= rd;
  // Read result is taken off the oldest note
  always @(negedge clock) begin
    if (rd_q === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      chk(rdata & n.m, n.v & n.m);
    end
  end
  initial begin
    #(25 * 4000);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {discard_event, fiq_enable, timer4_zero} = 3'h0;
    {central_strap, enq_req, irq_enable, serr_enable} = 4'hF;
    seed = 32'h0000_005B;
    do_reset(2'h2);
    chk(pci_rst_n, 0);
    chk(fifo_flush, 1);
    chk(enq_ok, 0);
    chk(rom_width, 2'h2);
    rd_chk(OFS_HOST_CTRL, 32'h0000_8000, 32'h7FFF_FF00);
    for (int i = 0; i < 8; i++) begin
      w = rnd() & 32'hFFFF_DCFD | 32'h0000_0200;
      w[LSZ_HI:LSZ_LO] = i[2:0];
      w[ACC_HI:ACC_LO] = i[3:0];
      w[BST_HI:BST_LO] = i[3:0] ^ 4'h3;
      enq_req = w[0];
      wreg(OFS_HOST_CTRL, w);
      chk(list_size, i);
      chk(list_mask, ((32'h0000_0400 << i) - 32'h1) & 32'hFFFF_FFFC);
      chk(rom_access, i == 0 ? 16 : i);
      chk(rom_burst, i == 3 ? 16 : i ^ 3);
      chk(rom_tristate, w[TRI_HI:TRI_LO]);
      chk(xcs_dir, w[XCS_HI:XCS_LO]);
      chk(rom_time_bad, i inside {1, 2} || (i ^ 3) inside {1, 2} || w[27:24] == 1);
      chk({pci_rst_n, fifo_flush, enq_ok}, {2'h2, w[0]});
      rd_chk(OFS_HOST_CTRL, w & 32'hFFFF_3FFF | 32'h8000, 32'h7FFF_FF00);
    end
    // Software PCI reset held long enough, then strap dropped
    enq_req = 1'b1;
    cpu.access(OFS_HOST_CTRL, w & 32'hFFFF_FDFF, 1'b1);
    step(8);
    chk({pci_rst_n, fifo_flush, enq_ok}, 3'h2);
    central_strap = 1'b0;
    step(3);
    chk({pci_rst_n, fifo_flush}, 2'h3);
    wreg(OFS_HOST_CTRL, w);
    discard_event = 1'b1;
    step(1);
    discard_event = 1'b0;
    step(3);
    chk({irq, fiq}, 2'h2);
    {irq_enable, fiq_enable} = 2'h1;
    step(3);
    chk({irq, fiq}, 2'h1);
    wreg(OFS_HOST_CTRL, w | 32'h100);
    rd_chk(OFS_HOST_CTRL, 32'h100, 32'h100);
    wreg(OFS_HOST_CTRL, w);
    chk(fiq, 0);
    rd_chk(OFS_HOST_CTRL, 32'h0, 32'h100);
    wreg(OFS_HOST_CTRL, w | 32'h2000);
    wreg(OFS_HOST_CTRL, w);
    rd_chk(OFS_HOST_CTRL, 32'h2000, 32'h2000);
    timer4_zero = 1'b1;
    step(3);
    chk(wdog_reset, 1);
    timer4_zero = 1'b0;
    for (int s = 0; s < 3; s++) begin
      central_strap = s[0];
      serr_enable = (s != 2);
      cpu.access(OFS_HOST_CTRL, w | 32'h2, 1'b1);
      cnt = 0;
      repeat (6) begin
        step(1);
        if (serr_n !== 1'b1) cnt++;
      end
      chk(cnt, s == 0);
    end
    w = rnd();
    wreg(OFS_ADDR_EXT, w);
    chk({pci_a31, pci_io_hi}, {w[15], w[31:16]});
    rd_chk(OFS_ADDR_EXT, w & 32'hFFFF_8000, 32'hFFFF_FFFF);
    wreg(OFS_DAC_HI, rnd());
    chk(pci_a31, 1);
    rd_chk(OFS_A31_ALIAS, 32'h1, 32'h1);
    wreg(OFS_DAC_LO, 32'hFFFF_FFFF);
    chk(pci_a31, 0);
    rd_chk(OFS_A31_ALIAS, 32'h0, 32'h1);
    wreg(12'h3F0, 32'hFFFF_FFFF);
    rd_chk(12'h3F0, 32'h0, 32'hFFFF_FFFF);
    do_reset(2'h1);
    chk(rom_width, 2'h1);
    rd_chk(OFS_HOST_CTRL, 32'h4000, 32'h7FFF_FF00);
    step(3);
    final_report;
  end
endmodule
